// ==== design/pam_address_mode.sv ====
// Top: effective-address generation for the four memory addressing modes
`timescale 1ns/100ps
`default_nettype none
module pam_address_mode #(
  parameter int NUM_SPACES = pam_pkg::NUM_SPACES_DEF,
  parameter int SPACE_W = (NUM_SPACES > 1) ? $clog2(NUM_SPACES) : 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Program status doubleword reload
  input wire logic psdLoad,
  input wire logic psdMapped,
  input wire logic psdExtended,
  input wire logic [SPACE_W-1:0] psdSpace,
  // Map entry load
  input wire logic mapWrEn,
  input wire logic [SPACE_W-1:0] mapWrSpace,
  input wire logic mapWrExt,
  input wire logic [pam_pkg::LOG_BLK_W-1:0] mapWrBlock,
  input wire logic [pam_pkg::PHYS_BLK_W-1:0] mapWrPhys,
  input wire logic mapWrValid,
  // Access request
  input wire logic reqValid,
  input wire logic reqFetch,
  input wire logic reqExt,
  input wire logic reqBitAccess,
  input wire logic [pam_pkg::ADDR_PHYS_W-1:0] reqAddr,
  input wire logic [pam_pkg::BIT_SEL_W-1:0] reqRegSel,
  // Access result
  output logic rspValid,
  output logic rspFault,
  output logic [pam_pkg::ADDR_PHYS_W-1:0] rspAddr,
  output logic rspBitAccess,
  output logic [pam_pkg::BIT_SEL_W-1:0] rspBitIndex,
  output pam_pkg::pam_mode_t activeMode,
  output logic [SPACE_W-1:0] activeSpace
);
  import pam_pkg::*;

  pam_mode_t mode_ff;
  logic [SPACE_W-1:0] space_ff;
  logic rspValid_ff;
  logic rspFault_ff;
  logic [ADDR_PHYS_W-1:0] rspAddr_ff;
  logic rspBitAccess_ff;
  logic [BIT_SEL_W-1:0] rspBitIndex_ff;

  logic nxtFault;
  logic [ADDR_PHYS_W-1:0] nxtAddr;
  logic lkExt;
  logic [PHYS_BLK_W-1:0] lkPhys;
  logic lkValid;
  logic highClear;
  logic [ADDR_PHYS_W-1:0] lowAddr;
  logic [ADDR_PHYS_W-1:0] mappedAddr;

  function automatic pam_mode_t decode_mode(input logic mapped, input logic extended);
    pam_mode_t m;
    m = pam_mode_t'({mapped, extended});
    return m;
  endfunction

  // Mode and space only move on a doubleword reload
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_ff <= MODE_RESET;
      space_ff <= '0;
    end else if (psdLoad) begin
      mode_ff <= decode_mode(psdMapped, psdExtended);
      space_ff <= psdSpace;
    end
  end

  assign highClear = (reqAddr[ADDR_PHYS_W-1:ADDR_LOG_W] == HIGH_ZERO);
  assign lowAddr = {HIGH_ZERO, reqAddr[ADDR_LOG_W-1:0]};
  // Fetches never look in the extended table
  assign lkExt = (mode_ff == PAM_MAPPED_EXT) && reqExt && !reqFetch;
  assign mappedAddr = {lkPhys, reqAddr[BLOCK_OFS_W-1:0]};

  pam_map_table #(
    .SPACE_W(SPACE_W)
  ) u_map (
    .clock(clock),
    .reset_n(reset_n),
    .wrEn(mapWrEn),
    .wrSpace(mapWrSpace),
    .wrExt(mapWrExt),
    .wrBlock(mapWrBlock),
    .wrPhys(mapWrPhys),
    .wrValid(mapWrValid),
    .lkSpace(space_ff),
    .lkExt(lkExt),
    .lkBlock(reqAddr[ADDR_LOG_W-1:BLOCK_OFS_W]),
    .lkPhys(lkPhys),
    .lkValid(lkValid)
  );

  always_comb begin
    nxtAddr = lowAddr;
    nxtFault = 1'b0;
    unique case (mode_ff)
      PAM_DIRECT: begin
        nxtAddr = lowAddr;
        nxtFault = !highClear;
      end
      PAM_EXTENDED: begin
        // Only operands may use the upper address bits
        nxtAddr = reqFetch ? lowAddr : reqAddr;
        nxtFault = reqFetch && !highClear;
      end
      PAM_MAPPED: begin
        nxtAddr = mappedAddr;
        nxtFault = !highClear || reqExt || !lkValid;
      end
      PAM_MAPPED_EXT: begin
        nxtAddr = mappedAddr;
        nxtFault = !highClear || (reqFetch && reqExt) || !lkValid;
      end
    endcase
  end

  // Result registers; address is dropped to zero on a fault so no stray access leaks
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rspValid_ff <= 1'b0;
      rspFault_ff <= 1'b0;
      rspAddr_ff <= '0;
    end else begin
      rspValid_ff <= reqValid;
      rspFault_ff <= reqValid && nxtFault;
      rspAddr_ff <= (reqValid && !nxtFault) ? nxtAddr : '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rspBitAccess_ff <= 1'b0;
      rspBitIndex_ff <= '0;
    end else begin
      rspBitAccess_ff <= reqValid && reqBitAccess;
      rspBitIndex_ff <= (reqValid && reqBitAccess) ? reqRegSel : '0;
    end
  end

  assign rspValid = rspValid_ff;
  assign rspFault = rspFault_ff;
  assign rspAddr = rspAddr_ff;
  assign rspBitAccess = rspBitAccess_ff;
  assign rspBitIndex = rspBitIndex_ff;
  assign activeMode = mode_ff;
  assign activeSpace = space_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_direct_pass;
    reqValid && mode_ff == PAM_DIRECT && highClear
      |=> rspValid && !rspFault && rspAddr == {HIGH_ZERO, $past(reqAddr[ADDR_LOG_W-1:0])};
  endproperty
  a_direct_pass: assert property (p_direct_pass) else $error("direct address altered");

  property p_direct_limit;
    reqValid && mode_ff == PAM_DIRECT && !highClear |=> rspFault && rspAddr == '0;
  endproperty
  a_direct_limit: assert property (p_direct_limit) else $error("direct access above limit not faulted");

  property p_bit_select;
    reqValid && reqBitAccess |=> rspBitAccess && rspBitIndex == $past(reqRegSel);
  endproperty
  a_bit_select: assert property (p_bit_select) else $error("bit index wrong");

  property p_ext_operand;
    reqValid && mode_ff == PAM_EXTENDED && !reqFetch |=> !rspFault && rspAddr == $past(reqAddr);
  endproperty
  a_ext_operand: assert property (p_ext_operand) else $error("extended operand not passed");

  property p_ext_fetch;
    reqValid && mode_ff == PAM_EXTENDED && reqFetch && !highClear |=> rspFault;
  endproperty
  a_ext_fetch: assert property (p_ext_fetch) else $error("extended fetch above limit not faulted");

  property p_mapped_xlate;
    reqValid && mode_ff == PAM_MAPPED && !reqExt && highClear && lkValid
      |=> !rspFault && rspAddr == {$past(lkPhys), $past(reqAddr[BLOCK_OFS_W-1:0])};
  endproperty
  a_mapped_xlate: assert property (p_mapped_xlate) else $error("mapped translation wrong");

  property p_space_switch;
    psdLoad |=> space_ff == $past(psdSpace);
  endproperty
  a_space_switch: assert property (p_space_switch) else $error("space not taken from reload");

  property p_ext_table;
    reqValid && mode_ff == PAM_MAPPED_EXT && reqExt && !reqFetch && highClear && lkValid
      |=> !rspFault ##0 rspAddr[ADDR_PHYS_W-1:BLOCK_OFS_W] == $past(lkPhys);
  endproperty
  a_ext_table: assert property (p_ext_table) else $error("extended space operand not mapped");

  property p_fetch_primary;
    reqValid && reqFetch |-> !lkExt ##1 (rspFault || !$past(reqExt) || $past(mode_ff) != PAM_MAPPED_EXT);
  endproperty
  a_fetch_primary: assert property (p_fetch_primary) else $error("fetch reached extended space");

  property p_mode_hold;
    !psdLoad |=> $stable(mode_ff) && $stable(space_ff);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed without reload");

  c_mapped_ok: cover property (reqValid && mode_ff == PAM_MAPPED && lkValid ##1 !rspFault);
  c_ext_space: cover property (reqValid && lkExt && lkValid ##1 !rspFault);
  c_ext_wide: cover property (reqValid && mode_ff == PAM_EXTENDED && !highClear && !reqFetch);
  c_mode_switch: cover property (psdLoad && psdMapped ##1 mode_ff == PAM_MAPPED);
endmodule
`default_nettype wire

// ==== design/pam_map_table.sv ====
// Map table: per-space primary and extended block translation entries
`timescale 1ns/100ps
`default_nettype none
module pam_map_table #(
  parameter int SPACE_W = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Write port
  input wire logic wrEn,
  input wire logic [SPACE_W-1:0] wrSpace,
  input wire logic wrExt,
  input wire logic [pam_pkg::LOG_BLK_W-1:0] wrBlock,
  input wire logic [pam_pkg::PHYS_BLK_W-1:0] wrPhys,
  input wire logic wrValid,
  // Lookup port
  input wire logic [SPACE_W-1:0] lkSpace,
  input wire logic lkExt,
  input wire logic [pam_pkg::LOG_BLK_W-1:0] lkBlock,
  output logic [pam_pkg::PHYS_BLK_W-1:0] lkPhys,
  output logic lkValid
);
  import pam_pkg::*;

  localparam int IDX_W = SPACE_W + 1 + LOG_BLK_W;
  localparam int DEPTH = 1 << IDX_W;

  logic [PHYS_BLK_W-1:0] physMem_ff [DEPTH];
  logic [DEPTH-1:0] validMem_ff;
  logic [IDX_W-1:0] wrIdx;
  logic [IDX_W-1:0] lkIdx;

  assign wrIdx = {wrSpace, wrExt, wrBlock};
  assign lkIdx = {lkSpace, lkExt, lkBlock};

  // Entries are independent, so one physical block may sit in several spaces
  always_ff @(posedge clock) begin
    if (wrEn) begin
      physMem_ff[wrIdx] <= wrPhys;
    end
  end

  // Only the presence bits need reset; stale block numbers are never used
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      validMem_ff <= '0;
    end else if (wrEn) begin
      validMem_ff[wrIdx] <= wrValid;
    end
  end

  assign lkPhys = physMem_ff[lkIdx];
  assign lkValid = validMem_ff[lkIdx];
endmodule
`default_nettype wire

// ==== design/pam_pkg.sv ====
// Package: address mode constants and types for the processor address mode logic
package pam_pkg;
  localparam int ADDR_LOG_W = 19;
  localparam int ADDR_PHYS_W = 24;
  localparam int BLOCK_OFS_W = 13;
  localparam int LOG_BLK_W = ADDR_LOG_W - BLOCK_OFS_W;
  localparam int PHYS_BLK_W = ADDR_PHYS_W - BLOCK_OFS_W;
  localparam int BIT_SEL_W = 3;
  localparam int NUM_SPACES_DEF = 4;
  localparam logic [ADDR_PHYS_W-ADDR_LOG_W-1:0] HIGH_ZERO = 5'h00;

  typedef enum logic [1:0] {
    PAM_DIRECT = 2'b00,
    PAM_EXTENDED = 2'b01,
    PAM_MAPPED = 2'b10,
    PAM_MAPPED_EXT = 2'b11
  } pam_mode_t;

  localparam pam_mode_t MODE_RESET = PAM_DIRECT;
endpackage

// ==== dv/pam_mem_model.sv ====
// Main memory model: counts physical accesses that reach memory
`timescale 1ns/100ps
`default_nettype none
module pam_mem_model (
  // Clock
  input wire logic clock,
  // Access from the block
  input wire logic rspValid,
  input wire logic rspFault,
  input wire logic [pam_pkg::ADDR_PHYS_W-1:0] rspAddr,
  // Statistics
  output var int hits
);
  int count = 0;
  // Faulted accesses never reach memory
  always @(posedge clock) begin
    if (rspValid === 1'b1 && rspFault === 1'b0 && rspAddr[23:0] !== 24'hxxxxxx) begin
      count <= count + 1;
    end
  end
  assign hits = count;
endmodule
`default_nettype wire

// ==== dv/tb_processor_address_mode_logic.sv ====
// Testbench for the processor address mode logic
`timescale 1ns/100ps
`default_nettype none
module tb_processor_address_mode_logic;
  import pam_pkg::*;
  logic clock = 0, reset_n = 0, psdLoad = 0, psdMapped = 0, psdExtended = 0;
  logic mapWrEn = 0, mapWrExt = 0, mapWrValid = 0, reqValid = 0, reqFetch = 0, reqExt = 0, reqBitAccess = 0;
  logic [1:0] psdSpace = 0, mapWrSpace = 0, activeSpace;
  logic [5:0] mapWrBlock = 0;
  logic [10:0] mapWrPhys = 0;
  logic [23:0] reqAddr = 0, rspAddr;
  logic [2:0] reqRegSel = 0, rspBitIndex;
  logic rspValid, rspFault, rspBitAccess;
  pam_mode_t activeMode;
  int mismatches = 0, checks = 0, mode = 0, space = 0, hits, expHits = 0;
  int map[int];
  logic [15:0] lf = 16'h2641, r1, r2;

  pam_address_mode #(.NUM_SPACES(4)) i_pam_address_mode (.clock, .reset_n, .psdLoad, .psdMapped, .psdExtended,
    .psdSpace, .mapWrEn, .mapWrSpace, .mapWrExt, .mapWrBlock, .mapWrPhys, .mapWrValid, .reqValid, .reqFetch,
    .reqExt, .reqBitAccess, .reqAddr, .reqRegSel, .rspValid, .rspFault, .rspAddr, .rspBitAccess, .rspBitIndex,
    .activeMode, .activeSpace);
  pam_mem_model i_pam_mem_model (.clock, .rspValid, .rspFault, .rspAddr, .hits);

  always #25 clock = ~clock;

  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, s);
      mismatches++;
    end
    checks++;
  endtask

  task automatic test_done();
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic program_status_doubleword(int m, int s);
    @(posedge clock);
    psdLoad <= 1;
    {psdMapped, psdExtended} <= m[1:0];
    psdSpace <= s[1:0];
    @(posedge clock);
    psdLoad <= 0;
    mode = m;
    space = s;
    #1 chk("mode", activeMode, m);
    chk("space", activeSpace, s);
  endtask

  task automatic mapw(int s, int x, int b, int p, bit v);
    @(posedge clock);
    {mapWrEn, mapWrValid, mapWrSpace, mapWrExt, mapWrBlock, mapWrPhys} <= {1'b1, v, s[1:0], x[0], b[5:0], p[10:0]};
    @(posedge clock);
    mapWrEn <= 0;
    map[s * 128 + x * 64 + b] = v ? p : -1;
  endtask

  task automatic acc(bit f, bit x, bit bt, logic [23:0] a, logic [2:0] r);
    bit hi, flt;
    int k;
    logic [23:0] ea;
    hi = a[23:19] != 5'h00;
    k = space * 128 + x * 64 + a[18:13];
    ea = a;
    flt = (mode == 0) ? hi : (mode == 1) ? f && hi : (mode == 2) ? hi || x : hi || (f && x);
    if (mode >= 2 && !flt) begin
      // Absent entries fault rather than pass through
      if (!map.exists(k) || map[k] < 0) flt = 1;
      else ea = {map[k][10:0], a[12:0]};
    end
    if (flt) ea = 0;
    else expHits++;
    @(posedge clock);
    {reqValid, reqFetch, reqExt, reqBitAccess, reqAddr, reqRegSel} <= {1'b1, f, x, bt, a, r};
    @(posedge clock);
    reqValid <= 0;
    #1 chk("rspValid", rspValid, 1);
    chk("rspFault", rspFault, flt);
    chk("rspAddr", rspAddr, ea);
    chk("rspBitAccess", rspBitAccess, bt);
    chk("rspBitIndex", rspBitIndex, bt ? r : 3'h0);
  endtask

  initial begin
    #100000;
    mismatches++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1;
    @(posedge clock);
    psdMapped <= 1;
    psdExtended <= 1;
    @(posedge clock);
    #1 chk("modeHold", activeMode, 0);
    // Block 0 shared by spaces 0 and 1 in both tables
    for (int s = 0; s < 2; s++) for (int x = 0; x < 2; x++) for (int b = 0; b < 3; b++)
      mapw(s, x, b, b == 0 ? 7 : s * 32 + x * 16 + b, 1);
    mapw(1, 0, 2, 0, 0);
    for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++) begin
      program_status_doubleword(m, s);
      for (int i = 0; i < 12; i++) begin
        lf = lfsr(lf);
        r1 = lf;
        lf = lfsr(lf);
        r2 = lf;
        acc(r2[13], r2[14], r2[15], {r1[15:14] == 0 ? r1[4:0] : 5'h00, r1[12] ? r1[10:5] : {4'h0, r1[6:5]},
          r2[12:0]}, r1[2:0]);
      end
    end
    repeat (2) @(posedge clock);
    chk("memHits", hits, expHits);
    test_done();
  end
endmodule
`default_nettype wire
